// *** logic/acp_config_port.sv ***
// Configuration port of a sampling converter: strap-selected parallel or
// serial programming, mode registers and power-down decode.
// Assumes all port pins are asynchronous to i_sys_clk and the serial clock
// is much slower than i_sys_clk (at least four system clocks per half).
//
// Contract
// - Sleep powers down whole converter, via register or serial-data pin in parallel.
// - Nap powers down core only, references stay; host allows 100 cycles.
// - Nap reachable only through power-down register in serial mode.
// - Mode-select high makes port pins static option levels, not serial.
// - Parallel mode: chip-select low stabilizer off, high on.
// - Parallel mode: serial clock low full-rate CMOS, high DDR LVDS 3.5mA.
// - Mode-select low forms serial port; one 16-bit word per write.
// - Transfer spans chip-select low; first 16 rising edges sampled only.
// - Word is read/write flag, seven address bits, eight data bits, MSB first.
// - Flag low writes register; high reads back, no update, input ignored.
// - Serial output open-drain, pulls low only; reader supplies pull-up.
// - Reset register bit 7 clears all registers; self-clears at write end.
// - Reset register is write-only; bits 6 to 0 have no effect.
// - Power-down field: 00 normal, 01 nap, 11 sleep, 10 unused.
// - Timing bit 3 inverts the output clock pair polarity.
// - Timing bits 2-1 delay output clock 0, 45, 90 or 135 degrees.
// - Timing bit 0 enables the clock duty-cycle stabilizer.
// - Output mode: 00 CMOS, 01 DDR LVDS, 10 DDR CMOS, 11 unused.
`timescale 1ns/1ns
`default_nettype none
`include "acp_map.svh"

module acp_config_port (
	input  wire logic               i_sys_clk,
	input  wire logic               i_rst_b,
	input  wire logic               i_port_mode_select_pin,
	input  wire logic               i_cs_b,
	input  wire logic               i_sck,
	input  wire logic               i_sdi,
	output var  logic               o_sdo,
	output var  logic               o_sdo_oe_b,
	output var  acp_pkg::acp_power_t    o_power_state,
	output var  logic               o_core_powered,
	output var  logic               o_refs_powered,
	output var  logic               o_duty_cycle_stabilizer_en,
	output var  logic               o_out_clock_invert,
	output var  logic [1:0]         o_out_clock_phase_field,
	output var  acp_pkg::acp_out_mode_t o_output_mode_field,
	output var  logic               o_lvds_internal_term_en
);
	import acp_pkg::*;

	// =====================================================================
	// Input synchronisers
	// =====================================================================
	logic [1:0] par_sync_r;
	logic [1:0] cs_sync_r;
	logic [1:0] sck_sync_r;
	logic [1:0] sdi_sync_r;
	logic       sck_prev_r;

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			par_sync_r <= 2'h0;
			cs_sync_r  <= 2'h3;
			sck_sync_r <= 2'h0;
			sdi_sync_r <= 2'h0;
			sck_prev_r <= 1'b0;
		end else begin
			par_sync_r <= {par_sync_r[0], i_port_mode_select_pin};
			cs_sync_r  <= {cs_sync_r[0], i_cs_b};
			sck_sync_r <= {sck_sync_r[0], i_sck};
			sdi_sync_r <= {sdi_sync_r[0], i_sdi};
			sck_prev_r <= sck_sync_r[1];
		end
	end

	logic par_mode;
	logic cs_b_s;
	logic sck_s;
	logic sdi_s;
	logic sck_rise;
	logic sck_fall;

	assign par_mode = par_sync_r[1];
	assign cs_b_s   = cs_sync_r[1];
	assign sck_s    = sck_sync_r[1];
	assign sdi_s    = sdi_sync_r[1];
	assign sck_rise = sck_s & ~sck_prev_r;
	assign sck_fall = ~sck_s & sck_prev_r;

	// =====================================================================
	// Serial transfer engine
	// =====================================================================
	acp_state_t                 state_r;
	logic [`ACP_WORD_CNT_W-1:0] bit_cnt_r;
	logic [`ACP_WORD_BITS-1:0]  shift_r;
	logic                       active;

	// serial port only with mode-select low
	// pins are static levels in parallel mode
	assign active = ~par_mode & ~cs_b_s;

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_r   <= ACP_ST_IDLE;
			bit_cnt_r <= '0;
			shift_r   <= '0;
		end else begin
			case (state_r)
				ACP_ST_IDLE: begin
					bit_cnt_r <= '0;
					if (active) begin
						state_r <= ACP_ST_SHIFT;
					end
				end
				ACP_ST_SHIFT: begin
					if (!active) begin
						state_r <= ACP_ST_IDLE;
					end else if (sck_rise) begin
						shift_r   <= {shift_r[`ACP_WORD_BITS-2:0], sdi_s};
						bit_cnt_r <= bit_cnt_r + `ACP_WORD_CNT_W'(1);
						if (bit_cnt_r == `ACP_WORD_CNT_W'(`ACP_WORD_BITS - 1)) begin
							state_r <= ACP_ST_DONE;
						end
					end
				end
				ACP_ST_DONE: begin
					if (!active) begin
						state_r <= ACP_ST_IDLE;
					end
				end
				default: begin
					state_r <= ACP_ST_IDLE;
				end
			endcase
		end
	end

	// Word fields once 16 bits have arrived
	logic       word_read;
	logic [6:0] word_addr;
	logic [7:0] word_data;
	logic       word_end;

	assign word_read = shift_r[15];
	assign word_addr = shift_r[14:8];
	assign word_data = shift_r[7:0];
	// Write commits when chip-select rises after a full word
	assign word_end  = (state_r == ACP_ST_DONE) & ~active;

	// =====================================================================
	// Mode control registers
	// =====================================================================
	logic [1:0] power_down_field_r;
	logic [3:0] timing_r;
	logic [1:0] output_mode_field_r;
	logic       wr_en;

	// only a write flag updates a register
	assign wr_en = word_end & ~word_read;

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			power_down_field_r  <= 2'(`ACP_REG_RESET_VAL);
			timing_r            <= 4'(`ACP_REG_RESET_VAL);
			output_mode_field_r <= 2'(`ACP_REG_RESET_VAL);
		end else if (wr_en) begin
			case (word_addr)
				`ACP_ADDR_SOFT_RESET: begin
					// bits 6 to 0 have no effect
					if (word_data[`ACP_SOFT_RESET_BIT]) begin
						power_down_field_r  <= 2'(`ACP_REG_RESET_VAL);
						timing_r            <= 4'(`ACP_REG_RESET_VAL);
						output_mode_field_r <= 2'(`ACP_REG_RESET_VAL);
					end
				end
				`ACP_ADDR_POWER_DOWN: begin
					power_down_field_r <= word_data[1:0];
				end
				`ACP_ADDR_OUT_CLK_TIMING: begin
					timing_r <= word_data[3:0];
				end
				`ACP_ADDR_OUTPUT_MODE: begin
					output_mode_field_r <= word_data[1:0];
				end
				default: begin
					power_down_field_r <= power_down_field_r;
				end
			endcase
		end
	end

	// =====================================================================
	// Read-back on the open-drain serial output
	// =====================================================================
	logic [7:0] rd_data;

	always_comb begin
		rd_data = 8'h00;
		// Address completes with the bit taken on the eighth rise
		case ({shift_r[5:0], sdi_s})
			`ACP_ADDR_POWER_DOWN:     rd_data = {6'h00, power_down_field_r};
			`ACP_ADDR_OUT_CLK_TIMING: rd_data = {4'h0, timing_r};
			`ACP_ADDR_OUTPUT_MODE:    rd_data = {6'h00, output_mode_field_r};
			default:                  rd_data = 8'h00;
		endcase
	end

	logic [7:0] rd_shift_r;
	logic       rd_on_r;
	logic       sdo_low_r;

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rd_shift_r <= 8'h00;
			rd_on_r    <= 1'b0;
			sdo_low_r  <= 1'b0;
		end else if (!active || state_r != ACP_ST_SHIFT) begin
			rd_on_r   <= 1'b0;
			sdo_low_r <= 1'b0;
		end else if (sck_rise && bit_cnt_r == `ACP_WORD_CNT_W'(7)) begin
			// load after the address; input data ignored
			rd_on_r    <= shift_r[6];
			rd_shift_r <= rd_data;
		end else if (sck_fall && rd_on_r) begin
			// Present next bit on falling edge, MSB first
			sdo_low_r  <= ~rd_shift_r[7];
			rd_shift_r <= {rd_shift_r[6:0], 1'b0};
		end
	end

	// open drain, only ever pulls low
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sdo      <= 1'b0;
			o_sdo_oe_b <= 1'b1;
		end else begin
			o_sdo      <= 1'b0;
			o_sdo_oe_b <= ~sdo_low_r;
		end
	end

	// =====================================================================
	// Mode outputs
	// =====================================================================
	acp_power_t    pwr_sel;
	acp_out_mode_t om_sel;
	logic          dcs_sel;

	always_comb begin
		if (par_mode) begin
			// no nap option in parallel mode
			pwr_sel = sdi_s ? ACP_PWR_SLEEP : ACP_PWR_NORMAL;
			// serial clock pin picks output mode
			om_sel  = sck_s ? ACP_OUT_DDR_LVDS : ACP_OUT_CMOS;
			dcs_sel = cs_b_s;
		end else begin
			pwr_sel = acp_power_t'(power_down_field_r);
			om_sel  = acp_out_mode_t'(output_mode_field_r);
			dcs_sel = timing_r[`ACP_TIMING_DCS_BIT];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_power_state              <= ACP_PWR_NORMAL;
			o_core_powered             <= 1'b1;
			o_refs_powered             <= 1'b1;
			o_duty_cycle_stabilizer_en <= 1'b0;
			o_output_mode_field        <= ACP_OUT_CMOS;
			o_lvds_internal_term_en    <= 1'b0;
		end else begin
			o_power_state              <= pwr_sel;
			o_core_powered             <= (pwr_sel == ACP_PWR_NORMAL) ||
			                              (pwr_sel == ACP_PWR_UNUSED);
			o_refs_powered             <= (pwr_sel != ACP_PWR_SLEEP);
			o_duty_cycle_stabilizer_en <= dcs_sel;
			o_output_mode_field        <= om_sel;
			o_lvds_internal_term_en    <= 1'b0;
		end
	end

	// Clock timing options exist only in serial mode
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_out_clock_invert      <= 1'b0;
			o_out_clock_phase_field <= 2'h0;
		end else if (par_mode) begin
			o_out_clock_invert      <= 1'b0;
			o_out_clock_phase_field <= 2'h0;
		end else begin
			o_out_clock_invert      <= timing_r[`ACP_TIMING_INV_BIT];
			o_out_clock_phase_field <=
				timing_r[`ACP_TIMING_PHASE_HI:`ACP_TIMING_PHASE_LO];
		end
	end

endmodule : acp_config_port
`default_nettype wire

// *** logic/acp_map.svh ***
// Register map, field positions, reset values and timing counts of the
// converter configuration port. Included by the package and the top module.
`ifndef ACP_MAP_SVH
`define ACP_MAP_SVH

`define ACP_ADDR_SOFT_RESET      7'h00
`define ACP_ADDR_POWER_DOWN      7'h01
`define ACP_ADDR_OUT_CLK_TIMING  7'h02
`define ACP_ADDR_OUTPUT_MODE     7'h03

`define ACP_SOFT_RESET_BIT       7
`define ACP_PD_MASK              8'h03
`define ACP_TIMING_MASK          8'h0F
`define ACP_OUTMODE_MASK         8'h03
`define ACP_TIMING_INV_BIT       3
`define ACP_TIMING_PHASE_HI      2
`define ACP_TIMING_PHASE_LO      1
`define ACP_TIMING_DCS_BIT       0

`define ACP_REG_RESET_VAL        8'h00
`define ACP_WORD_BITS            16
`define ACP_WORD_CNT_W           5

`define ACP_PD_NORMAL            2'h0
`define ACP_PD_NAP               2'h1
`define ACP_PD_UNUSED            2'h2
`define ACP_PD_SLEEP             2'h3

`define ACP_OM_CMOS              2'h0
`define ACP_OM_DDR_LVDS          2'h1
`define ACP_OM_DDR_CMOS          2'h2

`define ACP_SLEEP_WAKE_US        2000
`define ACP_NAP_WAKE_SAMPLES     100
`define ACP_NAP_SETTLE_US        50

`endif

// *** logic/acp_pkg.sv ***
// Types shared by the converter configuration port.
// Assumes acp_map.svh sits in the include path.
`include "acp_map.svh"

package acp_pkg;

	typedef enum logic [1:0] {
		ACP_PWR_NORMAL = `ACP_PD_NORMAL,
		ACP_PWR_NAP    = `ACP_PD_NAP,
		ACP_PWR_UNUSED = `ACP_PD_UNUSED,
		ACP_PWR_SLEEP  = `ACP_PD_SLEEP
	} acp_power_t;

	typedef enum logic [1:0] {
		ACP_OUT_CMOS     = `ACP_OM_CMOS,
		ACP_OUT_DDR_LVDS = `ACP_OM_DDR_LVDS,
		ACP_OUT_DDR_CMOS = `ACP_OM_DDR_CMOS,
		ACP_OUT_UNUSED   = 2'h3
	} acp_out_mode_t;

	// Gray coded: idle -> shift -> done
	typedef enum logic [1:0] {
		ACP_ST_IDLE  = 2'b00,
		ACP_ST_SHIFT = 2'b01,
		ACP_ST_DONE  = 2'b11
	} acp_state_t;

endpackage : acp_pkg

// *** tb/acp_config_port_props.sv ***
// Checker for the converter configuration port, bound to its top module.
// Assumes outputs settle within three clocks of a synchronised input.
`timescale 1ns/1ns
`default_nettype none

module acp_config_port_props
	import acp_pkg::*;
(
	input wire logic          i_sys_clk,
	input wire logic          i_rst_b,
	input wire logic          i_port_mode_select_pin,
	input wire logic          i_cs_b,
	input wire logic          i_sck,
	input wire logic          i_sdi,
	input wire logic          o_sdo,
	input wire logic          o_sdo_oe_b,
	input wire acp_power_t    o_power_state,
	input wire logic          o_core_powered,
	input wire logic          o_refs_powered,
	input wire logic          o_duty_cycle_stabilizer_en,
	input wire logic          o_out_clock_invert,
	input wire logic [1:0]    o_out_clock_phase_field,
	input wire acp_out_mode_t o_output_mode_field,
	input wire logic          o_lvds_internal_term_en
);
	// =========================================
	// Sequences
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	wire logic par;
	assign par = i_port_mode_select_pin;
	sequence par_held; par[*5]; endsequence
	sequence ser_held; (!par)[*6]; endsequence

	// =========================================
	// Assertions
	AST_NAP_CORE: assert property (o_power_state == ACP_PWR_NAP
		|-> !o_core_powered && o_refs_powered) else $error("nap power");
	AST_SLEEP_ALL: assert property (o_power_state == ACP_PWR_SLEEP
		|-> !o_core_powered && !o_refs_powered) else $error("sleep power");
	AST_RUN_ON: assert property (o_power_state[0] == 1'b0
		|-> o_core_powered && o_refs_powered) else $error("run power");
	AST_SDO_LOW: assert property (!o_sdo_oe_b |-> !o_sdo)
		else $error("sdo drives high");
	AST_SDO_IDLE: assert property (i_cs_b[*5] |-> o_sdo_oe_b)
		else $error("sdo held while deselected");
	AST_PAR_DCS: assert property ((par && $stable(i_cs_b))[*5]
		|-> o_duty_cycle_stabilizer_en == i_cs_b) else $error("par dcs");
	AST_PAR_SCK: assert property ((par && $stable(i_sck))[*5]
		|-> o_output_mode_field == (i_sck ? ACP_OUT_DDR_LVDS : ACP_OUT_CMOS)
		&& !o_lvds_internal_term_en) else $error("par output mode");
	AST_PAR_SDI: assert property ((par && $stable(i_sdi))[*5]
		|-> o_power_state == (i_sdi ? ACP_PWR_SLEEP : ACP_PWR_NORMAL))
		else $error("par sleep");
	AST_PAR_STATIC: assert property (par_held |-> !o_out_clock_invert
		&& o_out_clock_phase_field == 2'h0 && o_power_state != ACP_PWR_NAP)
		else $error("par timing");
	AST_WRITE_AT_CS: assert property (ser_held ##0
		$changed(o_out_clock_phase_field) |-> $past(i_cs_b, 3))
		else $error("update inside frame");
endmodule : acp_config_port_props

bind acp_config_port acp_config_port_props u_props (.*);

`default_nettype wire

// *** tb/acp_config_port_tb.sv ***
// Self-checking bench for the converter configuration port.
// Assumes the host model drives the serial pins in serial mode.
`timescale 1ns/1ns
`default_nettype none

module acp_config_port_tb;
	import acp_pkg::*;
	logic          clk = 1'b0;
	logic          rst_b = 1'b0;
	logic          mode = 1'b0;
	logic          cs_b, sck, sdi, sdo, oe_b, core, refs, duty_cycle_stabilizer_en, inv, term;
	logic [1:0]    ph;
	acp_power_t    pw;
	acp_out_mode_t om;
	logic [7:0]    rd;
	int            miscompares = 0;
	int            check_count = 0;
	int            k;
	// Address, write data, read-back, expected outputs
	logic [35:0] rows [11] = '{36'h01FD01140, 36'h0102022C0, 36'h010303300,
		36'h0100000C0, 36'h02F8080D0, 36'h0203030E4, 36'h0205050E8,
		36'h0207070EC, 36'h0301010ED, 36'h03FE020EE, 36'h0303030EF};

	initial begin
		forever #4 clk = ~clk;
	end

	acp_config_port dut (.i_sys_clk(clk), .i_rst_b(rst_b),
		.i_port_mode_select_pin(mode), .i_cs_b(cs_b), .i_sck(sck),
		.i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe_b(oe_b), .o_power_state(pw),
		.o_core_powered(core), .o_refs_powered(refs),
		.o_duty_cycle_stabilizer_en(duty_cycle_stabilizer_en), .o_out_clock_invert(inv),
		.o_out_clock_phase_field(ph), .o_output_mode_field(om),
		.o_lvds_internal_term_en(term));
	acp_host_model host (.o_cs_b(cs_b), .o_sck(sck), .o_sdi(sdi),
		.i_sdo(sdo), .i_sdo_oe_b(oe_b));

	// =========================================
	// Tasks
	function logic [11:0] obs();
		return {1'b0, term, pw, core, refs, duty_cycle_stabilizer_en, inv, ph, om};
	endfunction : obs

	task chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task results;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results

	task wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer({1'b0, a, d}, 16, 0, rd);
		repeat (6) @(negedge clk);
	endtask : wr

	task rdb(input logic [6:0] a, input logic [7:0] e);
		host.xfer({1'b1, a, 8'hFF}, 16, 0, rd);
		repeat (6) @(negedge clk);
		chk({4'h0, rd}, {4'h0, e});
	endtask : rdb

	// =========================================
	// Sequence
	initial begin
		#200_000;
		miscompares++;
		results();
	end

	initial begin
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		chk(obs(), 12'h0C0);
		chk({11'h0, oe_b}, 12'h001);
		wr(7'h00, 8'h80);
		foreach (rows[r]) begin
			wr(rows[r][34:28], rows[r][27:20]);
			chk(obs(), rows[r][11:0]);
			rdb(rows[r][34:28], rows[r][19:12]);
			chk(obs(), rows[r][11:0]);
		end
		host.xfer(16'h02F0, 12, 0, rd);
		repeat (6) @(negedge clk);
		chk(obs(), 12'h0EF);
		host.xfer(16'h0103, 16, 4, rd);
		repeat (6) @(negedge clk);
		chk(obs(), 12'h32F);
		wr(7'h05, 8'hFF);
		rdb(7'h05, 8'h00);
		wr(7'h00, 8'h7F);
		chk(obs(), 12'h32F);
		rdb(7'h00, 8'h00);
		wr(7'h00, 8'h80);
		chk(obs(), 12'h0C0);
		rdb(7'h02, 8'h00);
		wr(7'h02, 8'h0F);
		chk(obs(), 12'h0FC);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		chk(obs(), 12'h0C0);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		rdb(7'h02, 8'h00);
		wr(7'h01, 8'h01);
		mode = 1'b1;
		for (k = 0; k < 8; k++) begin
			host.pins(k[2], k[1], k[0]);
			repeat (6) @(negedge clk);
			chk(obs(), {2'h0, k[0] ? 2'h3 : 2'h0, ~k[0], ~k[0], k[2],
				3'h0, 1'b0, k[1]});
		end
		results();
	end
endmodule : acp_config_port_tb

`default_nettype wire

// *** tb/acp_host_model.sv ***
// Serial host model for the converter configuration port.
// Assumes the open-drain data line has a pull-up on the board.
`timescale 1ns/1ns
`default_nettype none

module acp_host_model (
	output var  logic o_cs_b,
	output var  logic o_sck,
	output var  logic o_sdi,
	input  wire logic i_sdo,
	input  wire logic i_sdo_oe_b
);
	// =========================================
	// Line level and pin driving
	wire logic sdo_line;
	assign sdo_line = i_sdo_oe_b ? 1'b1 : i_sdo;

	initial begin
		o_cs_b = 1'b1;
		o_sck  = 1'b0;
		o_sdi  = 1'b0;
	end

	task pins(input logic cs, input logic sck, input logic sdi);
		o_cs_b <= cs;
		o_sck  <= sck;
		o_sdi  <= sdi;
	endtask : pins

	// Pins change by non-blocking assignment: the 125 ns link period
	// drifts across the system clock and may land on its rising edge.
	// host reads no converted samples, so no settle wait is owed
	// frame of n bits plus extra edges
	task xfer(input logic [15:0] w, input int n, input int extra,
		output logic [7:0] rd);
		int i;
		rd = 8'h00;
		o_cs_b <= 1'b0;
		#63;
		for (i = 0; i < n + extra; i++) begin
			o_sdi <= (i < 16) ? w[15 - i] : ~o_sdi;
			#62;
			if (i >= 8 && i < 16) rd = {rd[6:0], sdo_line};
			o_sck <= 1'b1;
			#63;
			o_sck <= 1'b0;
		end
		#63;
		o_cs_b <= 1'b1;
		o_sdi  <= ~o_sdi;
		#63;
	endtask : xfer
endmodule : acp_host_model

`default_nettype wire
